// ===== tpc_pkg.sv
//------------------------------------------------------------
// Behaviour
// RULE_01: comparator select bit routes comparator result into channel 0 capture.
// RULE_02: with comparator routed, channel 0 pin is released, never driven.
// RULE_03: bus clock gate bit is set by reset; clearing it freezes the timer.
// RULE_04: prescaler divides by 1, 2, 4 ... 128, eight ratios.
// RULE_05: counter source is bus, fixed clock or external pin; slow ones synchronised.
// RULE_06: 16-bit counter, free-running or modulo, up or up/down.
// RULE_07: one to eight channels, a flag per channel plus an overflow flag.
// RULE_08: center mode bit forces all channels into center-aligned pwm.
// RULE_09: debug halt freezes counting until it is released.
// RULE_10: wait mode changes nothing; the timer keeps running.
// RULE_11: capture copies the counter into the channel value and sets the flag.
// RULE_12: capture edge is rising, falling, both or none; none disables the channel.
// RULE_13: compare match sets flag and drives low, high, toggles or leaves pin.
// RULE_14: edge pwm period is modulo plus one counts, value sets duty, polarity selectable.
// RULE_15: edge pwm flags at period end and at duty match; all start together.
// RULE_16: center pwm period is twice modulo, value is half the active time.
// RULE_17: center pwm counts up to modulo, then down to zero, repeating.
// RULE_18: center pwm goes active on down match, inactive on up match.
// RULE_19: modulo of all zeros or all ones gives a free-running counter.
// RULE_20: reading the counter never disturbs counting.
// RULE_21: any counter write clears the counter whatever the data.
// RULE_22: after reset nothing is enabled; unused pins stay with port control.
// RULE_23: high-true edge pwm goes high at zero, low at match; low-true inverts.
// RULE_24: up counting wraps to zero after the modulo value and sets overflow.
//------------------------------------------------------------
package tpc_pkg;

	localparam int TPC_CNT_W = 16;
	localparam int TPC_CH_MAX = 8;
	localparam int TPC_PS_W = 7;
	localparam logic [15:0] TPC_CNT_RST = 16'h0000;
	localparam logic [15:0] TPC_MOD_FREE_LO = 16'h0000;
	localparam logic [15:0] TPC_MOD_FREE_HI = 16'hffff;
	localparam logic TPC_GATE_RST = 1'h1;
	localparam logic [1:0] TPC_MODE_IC = 2'h0;
	localparam logic [1:0] TPC_MODE_OC = 2'h1;
	localparam logic [1:0] TPC_ELS_OFF = 2'h0;
	localparam logic [1:0] TPC_ELS_TOG = 2'h1;
	localparam logic [1:0] TPC_ELS_CLR = 2'h2;
	localparam logic [1:0] TPC_ELS_SET = 2'h3;

	// counter clock source select
	typedef enum logic [1:0] {TPC_CS_OFF, TPC_CS_BUS, TPC_CS_FIX, TPC_CS_EXT} tpc_clk_e;

	// counting direction
	typedef enum logic {TPC_UP, TPC_DOWN} tpc_dir_e;

endpackage : tpc_pkg

// ===== tpc_sync.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// two flop synchroniser, first stage read only by the second
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;

endmodule : tpc_sync
`default_nettype wire

// ===== tpc_chan.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_chan
	import tpc_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire logic i_on,
	input wire logic i_tick,
	input wire logic i_wrap,
	input wire logic i_down,
	input wire logic i_center_pwm_mode,
	input wire logic [TPC_CNT_W-1:0] i_cnt,
	input wire logic [1:0] i_mode,
	input wire logic [1:0] i_els,
	input wire logic i_pin,
	input wire logic i_blk,
	input wire logic i_val_wr,
	input wire logic [TPC_CNT_W-1:0] i_val_data,
	input wire logic i_flag_clr,
	output logic [TPC_CNT_W-1:0] o_val,
	output logic o_flag,
	output logic o_pin,
	output logic o_oe
);

	logic [TPC_CNT_W-1:0] val_ff;
	logic flag_ff;
	logic pin_ff;
	logic oe_ff;
	logic prev_ff;
	logic used;
	logic is_ic;
	logic is_oc;
	logic is_ep;
	logic cap;
	logic match;

	// channel function decode
	assign used = i_on & (i_els != TPC_ELS_OFF); // RULE_12 RULE_22
	assign is_ic = ~i_center_pwm_mode & (i_mode == TPC_MODE_IC); // RULE_08
	assign is_oc = ~i_center_pwm_mode & (i_mode == TPC_MODE_OC);
	assign is_ep = ~i_center_pwm_mode & i_mode[1];
	assign cap = i_en & used & is_ic & ((i_els[0] & i_pin & ~prev_ff) | (i_els[1] & ~i_pin & prev_ff)); // RULE_12
	assign match = i_en & i_tick & ~is_ic & (i_cnt == val_ff);

	// edge history of the synchronised input
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prev_ff <= 1'h0;
		end else if (i_en) begin
			prev_ff <= i_pin;
		end
	end

	// channel value: capture has priority over a write
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			val_ff <= TPC_CNT_RST;
		end else if (cap) begin
			val_ff <= i_cnt; // RULE_11
		end else if (i_en && i_val_wr) begin
			val_ff <= i_val_data;
		end
	end

	// sticky flag, a new event beats a clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flag_ff <= 1'h0;
		end else if (i_en) begin
			flag_ff <= (flag_ff & ~i_flag_clr) | cap | match; // RULE_07 RULE_11 RULE_13 RULE_15
		end
	end

	// pin level for compare and both pwm kinds
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pin_ff <= 1'h0;
		end else if (i_en && used) begin
			if (i_center_pwm_mode) begin
				if (match) begin
					pin_ff <= i_down ? ~i_els[0] : i_els[0]; // RULE_18
				end
			end else if (is_ep) begin
				if (i_wrap) begin
					pin_ff <= ~i_els[0]; // RULE_23 RULE_15
				end else if (match) begin
					pin_ff <= i_els[0]; // RULE_14 RULE_23
				end
			end else if (is_oc && match) begin
				case (i_els)
					TPC_ELS_TOG: pin_ff <= ~pin_ff; // RULE_13
					TPC_ELS_CLR: pin_ff <= 1'h0;
					TPC_ELS_SET: pin_ff <= 1'h1;
					default: pin_ff <= pin_ff;
				endcase
			end
		end
	end

	// drive enable, released to port control when unused
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			oe_ff <= 1'h0; // RULE_22
		end else if (i_en) begin
			oe_ff <= used & ~is_ic & ~i_blk; // RULE_02
		end
	end

	assign o_val = val_ff;
	assign o_flag = flag_ff;
	assign o_pin = pin_ff;
	assign o_oe = oe_ff;

endmodule : tpc_chan
`default_nettype wire

// ===== tpc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_timer
	import tpc_pkg::*;
#(
	parameter int NCH = TPC_CH_MAX
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_gate_wr,
	input wire logic i_gate_val,
	input wire logic [1:0] i_clk_sel,
	input wire logic [2:0] i_presc,
	input wire logic i_center_pwm_mode,
	input wire logic [TPC_CNT_W-1:0] i_mod_val,
	input wire logic i_cnt_wr,
	input wire logic i_ovf_clr,
	input wire logic i_bdm_halt,
	input wire logic i_fix_clk,
	input wire logic i_ext_clk,
	input wire logic i_analog_comparator_out,
	input wire logic i_analog_comparator_sel,
	input wire logic [2*NCH-1:0] i_ch_mode,
	input wire logic [2*NCH-1:0] i_ch_els,
	input wire logic [NCH-1:0] i_ch_val_wr,
	input wire logic [TPC_CNT_W*NCH-1:0] i_ch_val_data,
	input wire logic [NCH-1:0] i_ch_flag_clr,
	input wire logic [NCH-1:0] i_ch_pin,
	output logic [NCH-1:0] o_ch_pin_out,
	output logic [NCH-1:0] o_ch_pin_oe,
	output logic [NCH-1:0] o_ch_flag,
	output logic [TPC_CNT_W*NCH-1:0] o_ch_val,
	output logic [TPC_CNT_W-1:0] o_count,
	output logic o_ovf_flag,
	output logic o_gate,
	output logic o_ch0_taken
);

	//------------------------------------------------------------
	// parameter check
	//------------------------------------------------------------

	// between one and eight channels can be served
	generate
		if (NCH < 1 || NCH > TPC_CH_MAX) begin : g_bad_nch
			$error("tpc_timer: channel count out of range");
		end
	endgenerate

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------

	logic gate_ff;
	logic ch0_taken_ff;
	logic [TPC_CNT_W-1:0] cnt_ff;
	logic [TPC_CNT_W-1:0] nxt_cnt;
	tpc_dir_e dir_ff;
	tpc_dir_e nxt_dir;
	logic ovf_ff;
	logic ovf_evt;
	logic [TPC_PS_W-1:0] ps_ff;
	logic [TPC_PS_W-1:0] ps_mask;
	logic [NCH+2:0] sync_in;
	logic [NCH+2:0] sync_out;
	logic [NCH-1:0] pin_s;
	logic fix_s;
	logic ext_s;
	logic analog_comparator_s;
	logic fix_prev_ff;
	logic ext_prev_ff;
	logic src_tick;
	logic tick;
	logic run;
	logic wrap;
	logic free_run;
	logic [TPC_CNT_W-1:0] top;
	logic [NCH-1:0] cap_in;
	tpc_clk_e clk_sel;

	//------------------------------------------------------------
	// pin synchronisers
	//------------------------------------------------------------

	// every asynchronous input passes two flops before use
	assign sync_in = {i_analog_comparator_out, i_ext_clk, i_fix_clk, i_ch_pin};

	tpc_sync #(
		.W(NCH + 3)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(sync_in),
		.o_sync(sync_out)
	);

	assign pin_s = sync_out[NCH-1:0];
	assign fix_s = sync_out[NCH]; // RULE_05
	assign ext_s = sync_out[NCH+1];
	assign analog_comparator_s = sync_out[NCH+2];

	//------------------------------------------------------------
	// clock gate and comparator routing
	//------------------------------------------------------------

	// gate bit comes up set after every reset
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			gate_ff <= TPC_GATE_RST; // RULE_03
		end else if (i_gate_wr) begin
			gate_ff <= i_gate_val;
		end
	end

	// reports that channel 0 pin is withheld from the outside
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ch0_taken_ff <= 1'h0;
		end else begin
			ch0_taken_ff <= i_analog_comparator_sel; // RULE_02
		end
	end

	// channel 0 capture source: comparator or pin
	always_comb begin
		cap_in = pin_s;
		if (i_analog_comparator_sel) begin
			cap_in[0] = analog_comparator_s; // RULE_01
		end
	end

	//------------------------------------------------------------
	// counter clock source and prescaler
	//------------------------------------------------------------

	assign clk_sel = tpc_clk_e'(i_clk_sel);

	// edge history of the slow clock sources
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			fix_prev_ff <= 1'h0;
			ext_prev_ff <= 1'h0;
		end else begin
			fix_prev_ff <= fix_s;
			ext_prev_ff <= ext_s;
		end
	end

	// one pulse per source clock; wait mode does not affect it
	always_comb begin
		case (clk_sel)
			TPC_CS_BUS: src_tick = 1'h1; // RULE_05 RULE_10
			TPC_CS_FIX: src_tick = fix_s & ~fix_prev_ff;
			TPC_CS_EXT: src_tick = ext_s & ~ext_prev_ff;
			default: src_tick = 1'h0;
		endcase
	end

	// gate off or debug halt freezes the whole counting path
	assign run = gate_ff & ~i_bdm_halt; // RULE_09 RULE_03

	// power of two divider taps
	assign ps_mask = TPC_PS_W'((8'h01 << i_presc) - 8'h01); // RULE_04

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ps_ff <= '0;
		end else if (gate_ff && i_cnt_wr) begin
			ps_ff <= '0; // RULE_21
		end else if (run && src_tick) begin
			ps_ff <= ps_ff + TPC_PS_W'(1);
		end
	end

	assign tick = run & src_tick & ((ps_ff & ps_mask) == ps_mask); // RULE_04

	//------------------------------------------------------------
	// main counter
	//------------------------------------------------------------

	// all zeros or all ones modulo means free running
	assign free_run = (i_mod_val == TPC_MOD_FREE_LO) || (i_mod_val == TPC_MOD_FREE_HI); // RULE_19
	assign top = free_run ? TPC_MOD_FREE_HI : i_mod_val;
	assign wrap = tick & ~i_center_pwm_mode & (cnt_ff == top);

	// next count, direction and terminal count event
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_dir = dir_ff;
		ovf_evt = 1'h0;
		if (!i_center_pwm_mode) begin
			nxt_dir = TPC_UP;
			if (cnt_ff == top) begin
				nxt_cnt = TPC_CNT_RST; // RULE_24 RULE_06
				ovf_evt = 1'h1;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end else if (dir_ff == TPC_UP) begin
			if (cnt_ff >= top) begin
				nxt_dir = TPC_DOWN; // RULE_17
				nxt_cnt = cnt_ff - 16'h0001;
			end else begin
				nxt_cnt = cnt_ff + 16'h0001;
			end
		end else begin
			if (cnt_ff == TPC_CNT_RST) begin
				nxt_dir = TPC_UP; // RULE_17 RULE_16
				nxt_cnt = cnt_ff + 16'h0001;
				ovf_evt = 1'h1;
			end else begin
				nxt_cnt = cnt_ff - 16'h0001;
			end
		end
	end

	// counter register; a write clears it, reads have no side effect
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_ff <= TPC_CNT_RST;
			dir_ff <= TPC_UP;
		end else if (gate_ff && i_cnt_wr) begin
			cnt_ff <= TPC_CNT_RST; // RULE_21
			dir_ff <= TPC_UP;
		end else if (tick) begin
			cnt_ff <= nxt_cnt; // RULE_06 RULE_20
			dir_ff <= nxt_dir;
		end
	end

	// overflow flag, set beats clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ovf_ff <= 1'h0;
		end else if (gate_ff) begin
			ovf_ff <= (ovf_ff & ~i_ovf_clr) | (tick & ovf_evt); // RULE_24 RULE_07 RULE_15
		end
	end

	//------------------------------------------------------------
	// channels
	//------------------------------------------------------------

	// one channel instance per configured channel
	generate
		for (genvar g = 0; g < NCH; g++) begin : g_ch
			tpc_chan u_chan (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_en(gate_ff),
				.i_on(clk_sel != TPC_CS_OFF), // RULE_22
				.i_tick(tick),
				.i_wrap(wrap),
				.i_down(dir_ff == TPC_DOWN),
				.i_center_pwm_mode(i_center_pwm_mode), // RULE_08
				.i_cnt(cnt_ff),
				.i_mode(i_ch_mode[2*g +: 2]),
				.i_els(i_ch_els[2*g +: 2]),
				.i_pin(cap_in[g]),
				.i_blk((g == 0) && i_analog_comparator_sel), // RULE_02
				.i_val_wr(i_ch_val_wr[g]),
				.i_val_data(i_ch_val_data[TPC_CNT_W*g +: TPC_CNT_W]),
				.i_flag_clr(i_ch_flag_clr[g]),
				.o_val(o_ch_val[TPC_CNT_W*g +: TPC_CNT_W]),
				.o_flag(o_ch_flag[g]),
				.o_pin(o_ch_pin_out[g]),
				.o_oe(o_ch_pin_oe[g])
			);
		end
	endgenerate

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------

	assign o_count = cnt_ff;
	assign o_ovf_flag = ovf_ff;
	assign o_gate = gate_ff;
	assign o_ch0_taken = ch0_taken_ff;

endmodule : tpc_timer
`default_nettype wire

// ===== tpc_timer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_monitor
	import tpc_pkg::*;
#(
	parameter int NCH = TPC_CH_MAX
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_gate_wr,
	input wire logic [1:0] i_clk_sel,
	input wire logic [2:0] i_presc,
	input wire logic i_center_pwm_mode,
	input wire logic [TPC_CNT_W-1:0] i_mod_val,
	input wire logic i_cnt_wr,
	input wire logic i_bdm_halt,
	input wire logic i_analog_comparator_sel,
	input wire logic [NCH-1:0] o_ch_pin_oe,
	input wire logic [NCH-1:0] o_ch_flag,
	input wire logic [TPC_CNT_W-1:0] o_count,
	input wire logic o_ovf_flag,
	input wire logic o_gate,
	input wire logic o_ch0_taken
);
	// undivided bus clock, up counting, nothing holding the counter
	wire logic run = i_clk_sel == 2'h1 && i_presc == 3'h0 && o_gate && !i_gate_wr && !i_bdm_halt && !i_cnt_wr && !i_center_pwm_mode;
	wire logic [15:0] top = (i_mod_val == 16'h0000 || i_mod_val == 16'hffff) ? 16'hffff : i_mod_val;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_reset_clean: assert property ($fell(i_rst) |-> o_count == 16'h0000 && o_gate && o_ch_pin_oe == '0 && o_ch_flag == '0)
		else $error("bad state after reset");
	a_count_step: assert property (run && o_count < top |=> o_count == $past(o_count) + 16'h0001)
		else $error("counter did not step by one");
	a_count_wrap: assert property (run && o_count == top |=> o_count == 16'h0000 && o_ovf_flag)
		else $error("counter did not wrap with overflow");
	a_write_clears: assert property (i_cnt_wr && o_gate && !i_gate_wr |=> o_count == 16'h0000)
		else $error("counter write did not clear");
	a_halt_freeze: assert property ((i_bdm_halt && !i_cnt_wr) [*2] |=> $stable(o_count))
		else $error("counter moved while halted");
	a_gate_freeze: assert property ((!o_gate && !i_gate_wr) [*2] |=> $stable(o_count) && $stable(o_ovf_flag))
		else $error("timer moved with clock gated");
	a_comp_release: assert property (i_analog_comparator_sel [*2] |=> o_ch0_taken && !o_ch_pin_oe[0])
		else $error("channel zero pin still driven");
	a_off_no_drive: assert property ((i_clk_sel == 2'h0) [*2] |-> o_ch_pin_oe == '0)
		else $error("pin driven with timer off");
endmodule : tpc_timer_monitor
bind tpc_timer tpc_timer_monitor #(.NCH(NCH)) u_mon (.i_clk, .i_rst, .i_gate_wr, .i_clk_sel, .i_presc, .i_center_pwm_mode,
	.i_mod_val, .i_cnt_wr, .i_bdm_halt, .i_analog_comparator_sel, .o_ch_pin_oe, .o_ch_flag, .o_count, .o_ovf_flag, .o_gate,
	.o_ch0_taken);
`default_nettype wire

// ===== tpc_pins_model.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_pins_model (
	input wire logic i_clk,
	input wire logic [1:0] i_out,
	input wire logic [1:0] i_oe,
	input wire logic [1:0] i_lvl,
	input wire logic i_ext_run,
	output logic [1:0] o_pin,
	output logic o_ext_clk,
	output logic o_fix_clk
);
	logic [2:0] div_ff = 3'h0;
	// released pins follow the outside driver level
	assign o_pin = (i_oe & i_out) | (~i_oe & i_lvl);
	// slow clocks at one eighth rate, external one stands low when off
	always_ff @(posedge i_clk) begin
		div_ff <= div_ff + 3'h1;
	end
	assign o_fix_clk = div_ff[2];
	assign o_ext_clk = i_ext_run & div_ff[2];
endmodule : tpc_pins_model
`default_nettype wire

// ===== test_timer_pwm_capture_compare.sv
`timescale 1ns/100ps
`default_nettype none
module test_timer_pwm_capture_compare;
	logic i_clk = 1'h0, i_rst = 1'h1, i_gate_wr = 1'h0, i_gate_val = 1'h1, i_center_pwm_mode = 1'h0, i_cnt_wr = 1'h0;
	logic i_ovf_clr = 1'h0, i_bdm_halt = 1'h0, i_analog_comparator_out = 1'h0, i_analog_comparator_sel = 1'h0, ext_run = 1'h0;
	logic [1:0] i_clk_sel = 2'h1, i_ch_val_wr = 2'h0, i_ch_flag_clr = 2'h0, lvl = 2'h3;
	logic [2:0] i_presc = 3'h0;
	logic [3:0] i_ch_mode = 4'h0, i_ch_els = 4'h0;
	logic [15:0] i_mod_val = 16'h0000, seen;
	logic [31:0] i_ch_val_data = 32'h0;
	wire logic i_fix_clk, i_ext_clk, o_ovf_flag, o_gate, o_ch0_taken;
	wire logic [1:0] i_ch_pin, o_ch_pin_out, o_ch_pin_oe, o_ch_flag;
	wire logic [15:0] o_count;
	wire logic [31:0] o_ch_val;
	int n_errors = 0, checked = 0, cycles = 0;
	logic [15:0] exp_q[$];
	event res_e;
	tpc_timer #(.NCH(2)) dut (.i_clk, .i_rst, .i_gate_wr, .i_gate_val, .i_clk_sel, .i_presc, .i_center_pwm_mode, .i_mod_val,
		.i_cnt_wr, .i_ovf_clr, .i_bdm_halt, .i_fix_clk, .i_ext_clk, .i_analog_comparator_out, .i_analog_comparator_sel, .i_ch_mode, .i_ch_els,
		.i_ch_val_wr, .i_ch_val_data, .i_ch_flag_clr, .i_ch_pin, .o_ch_pin_out, .o_ch_pin_oe, .o_ch_flag, .o_ch_val,
		.o_count, .o_ovf_flag, .o_gate, .o_ch0_taken);
	tpc_pins_model pins (.i_clk, .i_out(o_ch_pin_out), .i_oe(o_ch_pin_oe), .i_lvl(lvl), .i_ext_run(ext_run),
		.o_pin(i_ch_pin), .o_ext_clk(i_ext_clk), .o_fix_clk(i_fix_clk));
	// clock, hang guard and result checker
	always #20 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 9000) begin
			n_errors++;
			final_report();
		end
	end
	always @(res_e) begin
		compare(exp_q.pop_front(), seen);
	end
	task automatic compare(input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask : compare
	task automatic note(input logic [15:0] g, input logic [15:0] e);
		exp_q.push_back(e);
		seen = g;
		->res_e;
		#1;
	endtask : note
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	task automatic cyc_n(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc_n
	// halt first so new settings never meet a tick
	task automatic freeze();
		@(posedge i_clk);
		i_bdm_halt <= 1'h1;
		@(posedge i_clk);
	endtask : freeze
	task automatic go();
		i_cnt_wr <= 1'h1;
		i_ch_flag_clr <= 2'h3;
		i_ovf_clr <= 1'h1;
		@(posedge i_clk);
		{i_cnt_wr, i_ovf_clr, i_bdm_halt, i_ch_flag_clr, i_ch_val_wr} <= 7'h00;
	endtask : go
	task automatic watch(input int n, output int hi, output int rs, output int mx);
		logic pv;
		{hi, rs, mx} = 96'h0;
		#1 pv = o_ch_pin_out[1];
		repeat (n) begin
			@(posedge i_clk);
			#1 hi += o_ch_pin_out[1];
			rs += o_ch_pin_out[1] & ~pv;
			pv = o_ch_pin_out[1];
			if (o_count > mx) mx = o_count;
		end
	endtask : watch
	initial begin
		int hi, rs, mx, h2;
		logic [15:0] c;
		logic p0;
		void'($urandom(74602));
		cyc_n(2);
		i_rst <= 1'h0;
		#1 note({o_count[14:0], o_gate}, 16'h0001);
		note({12'h0, o_ch_pin_oe, o_ch_flag}, 16'h0000);
		@(posedge i_clk);
		i_mod_val <= 16'h0003;
		i_cnt_wr <= 1'h1;
		@(posedge i_clk);
		i_cnt_wr <= 1'h0;
		for (int i = 0; i < 6; i++) begin
			#1 note(o_count, 16'(i % 4));
			@(posedge i_clk);
		end
		#1 note(16'(o_ovf_flag), 16'h0001);
		for (int k = 0; k < 2; k++) begin
			@(posedge i_clk);
			i_mod_val <= 16'h0000;
			{i_bdm_halt, i_gate_wr, i_gate_val} <= {k == 0, k == 1, 1'h0};
			@(posedge i_clk);
			i_gate_wr <= 1'h0;
			cyc_n(2);
			#1 c = o_count;
			cyc_n(4);
			#1 note(o_count, c);
			{i_bdm_halt, i_gate_wr, i_gate_val} <= {1'h0, k == 1, 1'h1};
			cyc_n(2);
			i_gate_wr <= 1'h0;
			#1 c = o_count;
			cyc_n(4);
			#1 note(o_count, c + 16'h0004);
		end
		$display("test hold done");
		for (int p = 0; p < 8; p++) begin
			@(posedge i_clk);
			i_presc <= 3'(p);
			i_cnt_wr <= 1'h1;
			@(posedge i_clk);
			i_cnt_wr <= 1'h0;
			cyc_n(3 * (1 << p) + (1 << p) / 2);
			#1 note(o_count, 16'h0003);
		end
		for (int e = 1; e < 4; e++) begin
			freeze();
			{i_presc, i_mod_val, i_ch_mode, i_ch_els} <= {3'h0, 16'h0007, 4'h4, 2'(e), 2'h0};
			i_ch_val_data <= {16'($urandom_range(6, 1)), 16'h0000};
			i_ch_val_wr <= 2'h2;
			go();
			#1 p0 = o_ch_pin_out[1];
			cyc_n(8);
			#1 note({o_ch_flag[1], o_ch_pin_out[1]}, {1'h1, e == 1 ? ~p0 : e == 3});
		end
		$display("test compare done");
		for (int e = 0; e < 4; e++) begin
			freeze();
			{i_presc, i_ch_mode, i_ch_els, i_analog_comparator_sel} <= {3'h7, 4'h0, 2'(e), 2'(e), 1'h1};
			{lvl[1], i_analog_comparator_out} <= {2{e == 2}};
			go();
			cyc_n(300);
			{lvl[1], i_analog_comparator_out} <= ~{lvl[1], i_analog_comparator_out};
			cyc_n(10);
			#1 note(o_ch_flag, e == 0 ? 16'h0000 : 16'h0003);
			if (e != 0) note(o_ch_val[31:16], 16'h0002);
			if (e != 0) note(o_ch_val[15:0], 16'h0002);
		end
		$display("test capture done");
		for (int k = 0; k < 3; k++) begin
			freeze();
			{i_presc, i_mod_val, i_analog_comparator_sel, i_ch_mode, i_center_pwm_mode} <= {3'h0, k == 2 ? 16'h0004 : 16'h0007, 1'h0, 4'ha, k == 2};
			i_ch_els <= k == 1 ? 4'h5 : 4'ha;
			i_ch_val_data <= k == 2 ? 32'h00020002 : 32'h00030003;
			i_ch_val_wr <= 2'h3;
			go();
			cyc_n(8);
			watch(32, hi, rs, mx);
			note(16'(rs), 16'h0004);
			if (k == 0) note({o_ovf_flag, o_ch_flag}, 16'h0007);
			if (k == 1) note(16'(hi + h2), 16'h0020);
			if (k == 2) note({8'(mx), 8'(hi)}, 16'h0410);
			h2 = hi;
		end
		$display("test pwm done");
		for (int s = 0; s < 4; s++) begin
			freeze();
			{i_center_pwm_mode, i_mod_val, i_clk_sel, ext_run} <= {17'h0, 2'(s), 1'h1};
			go();
			cyc_n(80);
			#1 c = s == 0 ? 16'h0000 : s == 1 ? 16'h0050 : 16'h000a;
			note(16'(o_count + 16'h0001 - c < 16'h0003), 16'h0001);
		end
		$display("test clock source done");
		final_report();
	end
endmodule : test_timer_pwm_capture_compare
`default_nettype wire
